// ==== verilog/cfgr_regs.sv ====
/*
  indexed configuration registers five to fifteen with the decode and
  pin logic they steer.
  assumes the host bus (index and data strobes, address, aen) is
  synchronous to ref_clk and that cfg_mode comes from the mode logic.
*/

`timescale 1ns/1ps
`default_nettype none
module cfgr_regs #(
  parameter logic [7:0] DEVICE_ID = 8'h5A,   // arbitrary value
  parameter logic [7:0] REVISION_ID = 8'h01, // arbitrary value
  parameter int GAP_CYC = cfgr_pkg::NB_GAP_CYC
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // configuration access
  input wire logic cfg_mode,
  input wire logic idx_wr_stb,
  input wire logic dat_wr_stb,
  input wire logic dat_rd_stb,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  // host address decode
  input wire logic [10:0] isa_addr,
  input wire logic isa_aen,
  output logic fdc_cs,
  output logic ide_cs0,
  output logic ide_cs1,
  output logic gp_decode_output_n,
  // parallel port state
  input wire logic ecp_en,
  input wire logic pp_dir,
  // floppy controller side
  input wire logic fifo_en,
  input wire logic fdc_req_raw,
  input wire logic fdc_int_raw,
  input wire logic fdc_byte_done,
  input wire logic [3:0] ds_raw,
  input wire logic [3:0] mot_raw,
  output logic floppy_dma_request,
  output logic floppy_int_request,
  output logic [3:0] drive_select,
  output logic [3:0] motor_select,
  output logic shared_ds_pin,
  // setup values for other blocks
  output logic [1:0] densel_mode,
  output logic [7:0] drive_type_table,
  output logic [7:0] boot_drive_media_polarity,
  output logic [7:0] ecp_fifo_threshold
);
  logic [7:0] config_index_select_reg;  // selected index
  logic [7:0] floppy_ide_extended_setup_reg;
  logic [7:0] drive_type_table_reg;
  logic [7:0] boot_drive_media_polarity_reg;
  logic [7:0] gp_decode_addr_low_reg;
  logic [7:0] gp_decode_addr_high_reg;
  logic [7:0] ecp_fifo_threshold_reg;
  logic [7:0] test_bits_reg;
  logic [7:0] rdata_next;               // read mux
  logic wr_hit;                         // qualified data write
  logic [10:0] addr_eff;                // address with a10 gated
  logic [10:0] gp_cmp;                  // general decode compare value
  logic [10:0] fdc_base;                // selected floppy base
  logic [10:0] ide_base;                // selected ide command base
  logic [10:0] ide_ctl;                 // selected ide control pair

  cfgr_ctl_if ctl_bus ();

  // only the config mode may steer the bank
  assign wr_hit = cfg_mode && dat_wr_stb;

  // index select loads only while in config mode
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      config_index_select_reg <= cfgr_pkg::RST_INDEX;
    end else if (clk_en && cfg_mode && idx_wr_stb) begin
      config_index_select_reg <= host_wdata;
    end
  end

  // extended setup register, index five
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      floppy_ide_extended_setup_reg <= cfgr_pkg::RST_EXT_SETUP;
    end else if (clk_en && wr_hit &&
                 config_index_select_reg == cfgr_pkg::IDX_EXT_SETUP) begin
      floppy_ide_extended_setup_reg <= host_wdata;
    end
  end

  // drive type table; all ones means no known type yet
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      drive_type_table_reg <= cfgr_pkg::RST_DRV_TYPE;
    end else if (clk_en && wr_hit &&
                 config_index_select_reg == cfgr_pkg::IDX_DRV_TYPE) begin
      drive_type_table_reg <= host_wdata;
    end
  end

  // boot drive and media id polarity
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_drive_media_polarity_reg <= cfgr_pkg::RST_BOOT_POL;
    end else if (clk_en && wr_hit &&
                 config_index_select_reg == cfgr_pkg::IDX_BOOT_POL) begin
      boot_drive_media_polarity_reg <= host_wdata;
    end
  end

  // general decode compare address, low byte
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      gp_decode_addr_low_reg <= cfgr_pkg::RST_GP_LOW;
    end else if (clk_en && wr_hit &&
                 config_index_select_reg == cfgr_pkg::IDX_GP_LOW) begin
      gp_decode_addr_low_reg <= host_wdata;
    end
  end

  // general decode compare address, high bits
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      gp_decode_addr_high_reg <= cfgr_pkg::RST_GP_HIGH;
    end else if (clk_en && wr_hit &&
                 config_index_select_reg == cfgr_pkg::IDX_GP_HIGH) begin
      gp_decode_addr_high_reg <= host_wdata;
    end
  end

  // ecp fifo threshold
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ecp_fifo_threshold_reg <= cfgr_pkg::RST_ECP_THR;
    end else if (clk_en && wr_hit &&
                 config_index_select_reg == cfgr_pkg::IDX_ECP_THR) begin
      ecp_fifo_threshold_reg <= host_wdata;
    end
  end

  // test bits are stored and read back but steer nothing here;
  // software is expected to leave them at zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      test_bits_reg <= cfgr_pkg::RST_TEST;
    end else if (clk_en && wr_hit &&
                 config_index_select_reg == cfgr_pkg::IDX_TEST) begin
      test_bits_reg <= host_wdata;
    end
  end

  // read mux; reserved and unknown indices read zero, and no write
  // process above decodes 0B, 0C, 0D or 0E, so those writes vanish
  always_comb begin
    case (config_index_select_reg)
      cfgr_pkg::IDX_EXT_SETUP: rdata_next = floppy_ide_extended_setup_reg;
      cfgr_pkg::IDX_DRV_TYPE: rdata_next = drive_type_table_reg;
      cfgr_pkg::IDX_BOOT_POL: rdata_next = boot_drive_media_polarity_reg;
      cfgr_pkg::IDX_GP_LOW: rdata_next = gp_decode_addr_low_reg;
      cfgr_pkg::IDX_GP_HIGH: rdata_next = gp_decode_addr_high_reg;
      cfgr_pkg::IDX_ECP_THR: rdata_next = ecp_fifo_threshold_reg;
      cfgr_pkg::IDX_RSVD_B: rdata_next = 8'h00;
      cfgr_pkg::IDX_RSVD_C: rdata_next = 8'h00;
      cfgr_pkg::IDX_DEV_ID: rdata_next = DEVICE_ID;
      cfgr_pkg::IDX_REV_ID: rdata_next = REVISION_ID;
      cfgr_pkg::IDX_TEST: rdata_next = test_bits_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // read data captured on the strobe; outside config mode reads are
  // answered with zero so no setup leaks to normal traffic
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      host_rdata <= 8'h00;
      host_rvalid <= 1'b0;
    end else if (clk_en) begin
      host_rvalid <= dat_rd_stb;
      if (dat_rd_stb) begin
        host_rdata <= cfg_mode ? rdata_next : 8'h00;
      end
    end
  end

  // setup bits to the sub-blocks
  assign ctl_bus.non_burst =
    floppy_ide_extended_setup_reg[cfgr_pkg::BIT_NON_BURST];
  assign ctl_bus.swap_drv =
    floppy_ide_extended_setup_reg[cfgr_pkg::BIT_SWAP];
  assign ctl_bus.ext_decode =
    floppy_ide_extended_setup_reg[cfgr_pkg::BIT_EXT_DEC];
  assign ctl_bus.ds3_pin =
    floppy_ide_extended_setup_reg[cfgr_pkg::BIT_DS3_PIN];

  // decode bases from the secondary bits
  always_comb begin
    fdc_base = floppy_ide_extended_setup_reg[cfgr_pkg::BIT_FDC_SEC] ?
               cfgr_pkg::FDC_SEC_BASE : cfgr_pkg::FDC_PRI_BASE;
    if (floppy_ide_extended_setup_reg[cfgr_pkg::BIT_IDE_SEC]) begin
      ide_base = cfgr_pkg::IDE_SEC_BASE;
      ide_ctl = cfgr_pkg::IDE_SEC_CTL;
    end else begin
      ide_base = cfgr_pkg::IDE_PRI_BASE;
      ide_ctl = cfgr_pkg::IDE_PRI_CTL;
    end
  end

  // a10 is only meaningful to the general decode when ecp is on
  assign addr_eff = {isa_addr[10] & ecp_en, isa_addr[9:0]};
  assign gp_cmp = {gp_decode_addr_high_reg[2:0], gp_decode_addr_low_reg};

  // registered chip selects; every match waits for aen low
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fdc_cs <= 1'b0;
      ide_cs0 <= 1'b0;
      ide_cs1 <= 1'b0;
      gp_decode_output_n <= 1'b1;
    end else if (clk_en) begin
      fdc_cs <= !isa_aen && isa_addr[10:3] == fdc_base[10:3];
      ide_cs0 <= !isa_aen && isa_addr[10:3] == ide_base[10:3];
      ide_cs1 <= !isa_aen && isa_addr[10:1] == ide_ctl[10:1];
      gp_decode_output_n <= !(!isa_aen && addr_eff == gp_cmp);
    end
  end

  // plain register views for neighbouring blocks
  assign densel_mode = floppy_ide_extended_setup_reg[
    cfgr_pkg::BIT_DENSEL_HI:cfgr_pkg::BIT_DENSEL_LO];
  assign drive_type_table = drive_type_table_reg;
  assign boot_drive_media_polarity = boot_drive_media_polarity_reg;
  assign ecp_fifo_threshold = ecp_fifo_threshold_reg;

  // per-byte strobing of dma and interrupt requests
  cfgr_dma_strobe #(
    .GAP_CYC(GAP_CYC)
  ) u_dma (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .ctl(ctl_bus.dma),
    .fifo_en(fifo_en),
    .req_raw(fdc_req_raw),
    .int_raw(fdc_int_raw),
    .byte_done(fdc_byte_done),
    .dma_req(floppy_dma_request),
    .int_req(floppy_int_request)
  );

  // drive and motor select mapping
  cfgr_drive_map u_drv (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .ctl(ctl_bus.drv),
    .ds_raw(ds_raw),
    .mot_raw(mot_raw),
    .ecp_en(ecp_en),
    .pp_dir(pp_dir),
    .ds_out(drive_select),
    .mot_out(motor_select),
    .shared_pin(shared_ds_pin)
  );
endmodule
`default_nettype wire

// ==== verilog/cfgr_pkg.sv ====
/*
  constants of the indexed configuration bank: indices, reset values,
  field positions, decode bases and timing counts.
  assumes nothing; imported by name only, never with import.
*/
`default_nettype none
package cfgr_pkg;
  // register indices held in the select register
  localparam logic [7:0] IDX_EXT_SETUP = 8'h05;
  localparam logic [7:0] IDX_DRV_TYPE = 8'h06;
  localparam logic [7:0] IDX_BOOT_POL = 8'h07;
  localparam logic [7:0] IDX_GP_LOW = 8'h08;
  localparam logic [7:0] IDX_GP_HIGH = 8'h09;
  localparam logic [7:0] IDX_ECP_THR = 8'h0A;
  localparam logic [7:0] IDX_RSVD_B = 8'h0B;
  localparam logic [7:0] IDX_RSVD_C = 8'h0C;
  localparam logic [7:0] IDX_DEV_ID = 8'h0D;
  localparam logic [7:0] IDX_REV_ID = 8'h0E;
  localparam logic [7:0] IDX_TEST = 8'h0F;
  // values after reset
  localparam logic [7:0] RST_EXT_SETUP = 8'h00;
  localparam logic [7:0] RST_DRV_TYPE = 8'hFF;
  localparam logic [7:0] RST_BOOT_POL = 8'h00;
  localparam logic [7:0] RST_GP_LOW = 8'h00;
  localparam logic [7:0] RST_GP_HIGH = 8'h00;
  localparam logic [7:0] RST_ECP_THR = 8'h00;
  localparam logic [7:0] RST_TEST = 8'h00;
  localparam logic [7:0] RST_INDEX = 8'h00;
  // field positions in the floppy / ide extended setup register
  localparam int BIT_FDC_SEC = 0;
  localparam int BIT_IDE_SEC = 1;
  localparam int BIT_NON_BURST = 2;
  localparam int BIT_DENSEL_LO = 3;
  localparam int BIT_DENSEL_HI = 4;
  localparam int BIT_SWAP = 5;
  localparam int BIT_EXT_DEC = 6;
  localparam int BIT_DS3_PIN = 7;
  // host address decode, 11 address bits
  localparam int HOST_AW = 11;
  localparam logic [10:0] FDC_PRI_BASE = 11'h3F0;
  localparam logic [10:0] FDC_SEC_BASE = 11'h370;
  localparam logic [10:0] IDE_PRI_BASE = 11'h1F0;
  localparam logic [10:0] IDE_SEC_BASE = 11'h170;
  localparam logic [10:0] IDE_PRI_CTL = 11'h3F6;
  localparam logic [10:0] IDE_SEC_CTL = 11'h376;
  // non-burst request gap, in ns and in cycles of ref_clk (100 MHz)
  localparam int CLK_PERIOD_NS = 10;
  localparam int NB_GAP_NS = 10;
  localparam int NB_GAP_CYC = (NB_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ==== verilog/cfgr_ctl_if.sv ====
/*
  carrier of the decoded setup bits from the register bank to the
  drive-select mapper and the dma strobe shaper.
  assumes all parties run on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface cfgr_ctl_if;
  logic non_burst;   // single-byte dma handshakes
  logic swap_drv;    // exchange drives 0 and 1
  logic ext_decode;  // external 2-to-4 decoder fitted
  logic ds3_pin;     // shared pin always drive select three
  modport src (output non_burst, output swap_drv, output ext_decode,
               output ds3_pin);
  modport drv (input swap_drv, input ext_decode, input ds3_pin);
  modport dma (input non_burst);
endinterface
`default_nettype wire

// ==== verilog/cfgr_drive_map.sv ====
/*
  drive and motor select mapper: swap of drives 0/1, internal or
  external decode, use of the shared drive select pin.
  assumes raw selects come from floppy logic on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module cfgr_drive_map (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // setup
  cfgr_ctl_if.drv ctl,
  // selects from the floppy controller, active high, and parallel port state
  input wire logic [3:0] ds_raw,
  input wire logic [3:0] mot_raw,
  input wire logic ecp_en,
  input wire logic pp_dir,
  // pin side, registered
  output logic [3:0] ds_out,
  output logic [3:0] mot_out,
  output logic shared_pin
);
  logic [3:0] ds_sw;  // after optional swap
  logic [3:0] mot_sw;
  logic [3:0] ds_dec; // after decode choice

  // swap only drives 0 and 1, others pass
  always_comb begin
    ds_sw = ctl.swap_drv ? {ds_raw[3:2], ds_raw[0], ds_raw[1]} : ds_raw;
    mot_sw = ctl.swap_drv ? {mot_raw[3:2], mot_raw[0], mot_raw[1]} : mot_raw;
  end

  // external decoder wants a binary code plus an enable
  always_comb begin
    if (ctl.ext_decode) begin
      ds_dec = {1'b0, |ds_sw, ds_sw[3] | ds_sw[2], ds_sw[3] | ds_sw[1]};
    end else begin
      ds_dec = ds_sw;
    end
  end

  // registered pin outputs
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ds_out <= 4'h0;
      mot_out <= 4'h0;
      shared_pin <= 1'b0;
    end else if (clk_en) begin
      ds_out <= ds_dec;
      mot_out <= mot_sw;
      // pin carries parallel direction only when ecp owns it
      if (ctl.ds3_pin) begin
        shared_pin <= ds_dec[3];
      end else begin
        shared_pin <= ecp_en ? pp_dir : ds_dec[2];
      end
    end
  end
endmodule
`default_nettype wire

// ==== verilog/cfgr_dma_strobe.sv ====
/*
  dma / interrupt request shaper for the floppy fifo: passes requests
  in burst mode, strobes them once per byte in non-burst mode while fifo_en is high.
  assumes byte_done is a one-cycle pulse on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module cfgr_dma_strobe #(
  parameter int GAP_CYC = cfgr_pkg::NB_GAP_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // setup
  cfgr_ctl_if.dma ctl,
  // from the floppy fifo
  input wire logic fifo_en,
  input wire logic req_raw,
  input wire logic int_raw,
  input wire logic byte_done,
  // shaped requests, handshake outputs
  output logic dma_req,
  output logic int_req
);
  logic [7:0] gap_reg; // cycles left with requests dropped
  logic strobing;      // non-burst shaping active

  // refuse gaps that the 8-bit counter cannot hold
  if (GAP_CYC < 1 || GAP_CYC > 255) begin : g_gap_check
    $error("GAP_CYC out of range");
  end

  assign strobing = ctl.non_burst && fifo_en;

  // drop requests for a gap after each byte so each byte gets a strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_reg <= 8'h00;
    end else if (clk_en) begin
      if (strobing && byte_done) begin
        gap_reg <= 8'(GAP_CYC);
      end else if (gap_reg != 8'h00) begin
        gap_reg <= gap_reg - 8'h01;
      end
    end
  end

  // burst mode passes straight; the request stays low through the gap
  assign dma_req = req_raw && !(strobing && (byte_done || gap_reg != 8'h00));
  assign int_req = int_raw && !(strobing && (byte_done || gap_reg != 8'h00));
endmodule
`default_nettype wire

// ==== bench/cfgr_regs_monitor.sv ====
/*
  checker for the configuration bank, watching top ports only.
  assumes clk_en is held high and the bank is bound from tb.
*/
`timescale 1ns/1ps
`default_nettype none
module cfgr_regs_monitor #(
  parameter logic [7:0] DEVICE_ID = 8'h5A,  // arbitrary value
  parameter logic [7:0] REVISION_ID = 8'h01 // arbitrary value
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // host access
  input wire logic cfg_mode,
  input wire logic idx_wr_stb,
  input wire logic dat_wr_stb,
  input wire logic dat_rd_stb,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic host_rvalid,
  // address decode
  input wire logic [10:0] isa_addr,
  input wire logic isa_aen,
  input wire logic fdc_cs,
  input wire logic ide_cs0,
  input wire logic ide_cs1,
  input wire logic gp_decode_output_n,
  // floppy requests and setup views
  input wire logic fifo_en,
  input wire logic fdc_req_raw,
  input wire logic fdc_byte_done,
  input wire logic floppy_dma_request,
  input wire logic floppy_int_request,
  input wire logic [7:0] drive_type_table,
  input wire logic [7:0] ecp_fifo_threshold
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic [7:0] idx_reg;  // shadow of the select register
  logic nb_reg;         // shadow of the dma mode bit
  // shadows, so the checker knows which byte the host points at
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      idx_reg <= 8'h00;
    end else if (idx_wr_stb && cfg_mode) begin
      idx_reg <= host_wdata;
    end
  end
  // dma mode shadow, only an accepted write to index 05 moves it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      nb_reg <= 1'b0;
    end else if (dat_wr_stb && cfg_mode && idx_reg == 8'h05) begin
      nb_reg <= host_wdata[2];
    end
  end
  sequence s_wr(logic [7:0] i);
    dat_wr_stb && cfg_mode && idx_reg == i;
  endsequence
  sequence s_rd(logic [7:0] i);
    dat_rd_stb && cfg_mode && idx_reg == i;
  endsequence
  sequence s_quiet;
    !floppy_dma_request && !floppy_int_request;
  endsequence
  property p_rvalid; dat_rd_stb |=> host_rvalid; endproperty
  a_rvalid: assert property (p_rvalid)
    else $error("read strobe not answered");
  property p_locked; dat_rd_stb && !cfg_mode |=> host_rdata == 8'h00;
  endproperty
  a_locked: assert property (p_locked)
    else $error("read outside config mode gave data");
  property p_drv_type;
    s_wr(8'h06) |=> drive_type_table == $past(host_wdata);
  endproperty
  a_drv_type: assert property (p_drv_type)
    else $error("drive type view not updated");
  property p_ecp_thr;
    s_wr(8'h0A) |=> ecp_fifo_threshold == $past(host_wdata);
  endproperty
  a_ecp_thr: assert property (p_ecp_thr)
    else $error("ecp threshold view not updated");
  property p_dev_id; s_rd(8'h0D) |=> host_rdata == DEVICE_ID; endproperty
  a_dev_id: assert property (p_dev_id)
    else $error("device ident wrong");
  property p_rev_id; s_rd(8'h0E) |=> host_rdata == REVISION_ID; endproperty
  a_rev_id: assert property (p_rev_id)
    else $error("revision ident wrong");
  property p_fdc_win;
    fdc_cs |-> !$past(isa_aen) && $past(isa_addr[10:3]) inside {8'h7E, 8'h6E};
  endproperty
  a_fdc_win: assert property (p_fdc_win)
    else $error("floppy select outside its windows");
  property p_ide_win; ide_cs0 |-> $past(isa_addr[10:3]) inside {8'h3E, 8'h2E};
  endproperty
  a_ide_win: assert property (p_ide_win)
    else $error("ide command select outside its windows");
  property p_ide_ctl;
    ide_cs1 |-> $past(isa_addr[10:1]) inside {10'h1FB, 10'h1BB};
  endproperty
  a_ide_ctl: assert property (p_ide_ctl)
    else $error("ide control select outside its windows");
  property p_gp_aen; isa_aen |=> gp_decode_output_n; endproperty
  a_gp_aen: assert property (p_gp_aen)
    else $error("general decode matched a dma cycle");
  property p_burst; !nb_reg |-> floppy_dma_request == fdc_req_raw; endproperty
  a_burst: assert property (p_burst)
    else $error("burst request not passed through");
  property p_nb_strobe;
    nb_reg && fifo_en && fdc_byte_done |-> s_quiet ##1 s_quiet;
  endproperty
  a_nb_strobe: assert property (p_nb_strobe)
    else $error("non-burst request not strobed");
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
/*
  self-checking bench for the configuration bank top.
  assumes inputs change on the falling edge; clk_en tied high.
*/
`timescale 1ns/1ps
`default_nettype none
bind cfgr_regs cfgr_regs_monitor #(.DEVICE_ID(DEVICE_ID),
  .REVISION_ID(REVISION_ID)) i_cfgr_regs_monitor (.ref_clk(ref_clk),
  .arst_n(arst_n), .cfg_mode(cfg_mode), .idx_wr_stb(idx_wr_stb),
  .dat_wr_stb(dat_wr_stb), .dat_rd_stb(dat_rd_stb),
  .host_wdata(host_wdata), .host_rdata(host_rdata),
  .host_rvalid(host_rvalid), .isa_addr(isa_addr), .isa_aen(isa_aen),
  .fdc_cs(fdc_cs), .ide_cs0(ide_cs0), .ide_cs1(ide_cs1),
  .gp_decode_output_n(gp_decode_output_n), .fifo_en(fifo_en),
  .fdc_req_raw(fdc_req_raw), .fdc_byte_done(fdc_byte_done),
  .floppy_dma_request(floppy_dma_request),
  .floppy_int_request(floppy_int_request),
  .drive_type_table(drive_type_table),
  .ecp_fifo_threshold(ecp_fifo_threshold));
module tb;
  localparam logic [7:0] DEV_ID = 8'h5A; // arbitrary value
  localparam logic [7:0] REV_ID = 8'h01; // arbitrary value
  // expected read values of indices 05..0F after reset
  localparam logic [7:0] RST_TAB [11] = '{8'h00, 8'hFF, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, DEV_ID, REV_ID, 8'h00};
  // decode cases: bit 15 secondary, 14:4 address, 3:0 {fdc,ide0,ide1,gp_n}
  localparam logic [15:0] DEC_TAB [10] = '{16'h3F09, 16'h3F7B, 16'h1F55,
    16'h3701, 16'h3F81, 16'hB709, 16'hB77B, 16'h9765, 16'hBF01, 16'hBF71};
  logic ref_clk = 1'b0, arst_n = 1'b0, cfg_mode = 1'b1;
  logic idx_wr_stb = 1'b0, dat_wr_stb = 1'b0, dat_rd_stb = 1'b0;
  logic [7:0] host_wdata = 8'h00, host_rdata, drive_type_table;
  logic [7:0] ecp_fifo_threshold, boot_pol;
  logic [10:0] isa_addr = 11'h000;
  logic isa_aen = 1'b0, ecp_en = 1'b0, fifo_en = 1'b0, pp_dir = 1'b0;
  logic fdc_req_raw = 1'b0, fdc_int_raw = 1'b0, fdc_byte_done = 1'b0;
  logic [3:0] ds_raw = 4'h0, drive_select, motor_select;
  logic host_rvalid, fdc_cs, ide_cs0, ide_cs1, gp_decode_output_n;
  logic floppy_dma_request, floppy_int_request, shared_ds_pin;
  int n_errors = 0, checked = 0;
  cfgr_regs #(.DEVICE_ID(DEV_ID), .REVISION_ID(REV_ID), .GAP_CYC(1))
  i_cfgr_regs (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(1'b1),
    .cfg_mode(cfg_mode), .idx_wr_stb(idx_wr_stb), .dat_wr_stb(dat_wr_stb),
    .dat_rd_stb(dat_rd_stb), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .isa_addr(isa_addr), .isa_aen(isa_aen), .fdc_cs(fdc_cs),
    .ide_cs0(ide_cs0), .ide_cs1(ide_cs1),
    .gp_decode_output_n(gp_decode_output_n), .ecp_en(ecp_en),
    .pp_dir(pp_dir), .fifo_en(fifo_en), .fdc_req_raw(fdc_req_raw),
    .fdc_int_raw(fdc_int_raw), .fdc_byte_done(fdc_byte_done),
    .ds_raw(ds_raw), .mot_raw(ds_raw),
    .floppy_dma_request(floppy_dma_request),
    .floppy_int_request(floppy_int_request),
    .drive_select(drive_select), .motor_select(motor_select),
    .shared_ds_pin(shared_ds_pin), .densel_mode(),
    .drive_type_table(drive_type_table),
    .boot_drive_media_polarity(boot_pol),
    .ecp_fifo_threshold(ecp_fifo_threshold));
  // 100 MHz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one strobe cycle: s = {index write, data write, read}
  task automatic acc(input logic [2:0] s, input logic [7:0] d);
    @(negedge ref_clk);
    {idx_wr_stb, dat_wr_stb, dat_rd_stb} = s;
    host_wdata = d;
    @(negedge ref_clk);
    {idx_wr_stb, dat_wr_stb, dat_rd_stb} = 3'b000;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    acc(3'b100, i);
    acc(3'b010, d);
  endtask
  // answer lands one edge after the strobe, sampled here
  task automatic rd(input logic [7:0] i, input logic [7:0] exp);
    acc(3'b100, i);
    acc(3'b001, 8'h00);
    chk({7'h00, host_rvalid}, 8'h01);
    chk(host_rdata, exp);
  endtask
  // decodes are registered: one edge after the address
  task automatic probe(input logic [10:0] a, input logic e,
                       input logic [3:0] x);
    @(negedge ref_clk);
    isa_addr = a;
    isa_aen = e;
    @(negedge ref_clk);
    chk({4'h0, fdc_cs, ide_cs0, ide_cs1, gp_decode_output_n}, {4'h0, x});
  endtask
  // one byte handshake; non-burst drops requests for the byte and gap
  task automatic dma(input logic nb);
    wr(8'h05, {5'h00, nb, 2'b00});
    @(negedge ref_clk);
    fdc_byte_done = 1'b1;
    #1 chk({6'h00, floppy_dma_request, floppy_int_request}, 8'(nb ? 0 : 3));
    @(negedge ref_clk);
    fdc_byte_done = 1'b0;
    #1 chk({6'h00, floppy_dma_request, floppy_int_request}, 8'(nb ? 0 : 3));
    @(negedge ref_clk);
    chk({6'h00, floppy_dma_request, floppy_int_request}, 8'h03);
  endtask
  // drive map: setup byte, ecp owner, raw selects, expected pins
  task automatic dm(input logic [7:0] s, input logic e, input logic [3:0] d,
                    input logic [3:0] xd, input logic xp);
    wr(8'h05, s);
    @(negedge ref_clk);
    ecp_en = e;
    ds_raw = d;
    @(negedge ref_clk);
    chk({3'h0, drive_select, shared_ds_pin}, {3'h0, xd, xp});
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    #1000000;
    n_errors++;
    finish_test();
  end
  initial begin
    repeat (20) @(negedge ref_clk);
    arst_n = 1'b1;
    for (int k = 0; k < 11; k++) begin
      rd(8'(k + 5), RST_TAB[k]);
    end
    $display("test reset values done");
    // test bits only ever get zero from software
    for (int k = 1; k < 11; k++) begin
      wr(8'(k + 5), k == 10 ? 8'h00 : 8'(8'hA0 + k));
    end
    for (int k = 1; k < 11; k++) begin
      rd(8'(k + 5), k > 5 ? RST_TAB[k] : 8'(8'hA0 + k));
    end
    chk(drive_type_table, 8'hA1);
    chk(boot_pol, 8'hA2);
    chk(ecp_fifo_threshold, 8'hA5);
    $display("test write and read back done");
    cfg_mode = 1'b0;
    wr(8'h06, 8'h3C);
    acc(3'b001, 8'h00);
    chk(host_rdata, 8'h00);
    cfg_mode = 1'b1;
    rd(8'h06, 8'hA1);
    $display("test locked access done");
    for (int k = 0; k < 10; k++) begin
      wr(8'h05, {6'h00, {2{DEC_TAB[k][15]}}});
      probe(DEC_TAB[k][14:4], 1'b0, DEC_TAB[k][3:0]);
    end
    // secondary window is live here, so aen alone must block it
    probe(11'h370, 1'b1, 4'h1);
    $display("test window decode done");
    wr(8'h08, 8'h34);
    wr(8'h09, 8'h05);
    ecp_en = 1'b1;
    probe(11'h534, 1'b0, 4'h0);
    probe(11'h534, 1'b1, 4'h1);
    ecp_en = 1'b0;
    probe(11'h534, 1'b0, 4'h1);
    wr(8'h09, 8'h01);
    probe(11'h534, 1'b0, 4'h0);
    $display("test general decode done");
    fifo_en = 1'b1;
    fdc_req_raw = 1'b1;
    fdc_int_raw = 1'b1;
    dma(1'b1);
    dma(1'b0);
    $display("test dma mode done");
    dm(8'h20, 1'b0, 4'h1, 4'h2, 1'b0);
    chk({4'h0, motor_select}, 8'h02);
    dm(8'h00, 1'b0, 4'h1, 4'h1, 1'b0);
    dm(8'h40, 1'b1, 4'h8, 4'h7, 1'b0);
    dm(8'h80, 1'b1, 4'h8, 4'h8, 1'b1);
    dm(8'h00, 1'b1, 4'h4, 4'h4, 1'b0);
    dm(8'h00, 1'b0, 4'h4, 4'h4, 1'b1);
    // direction high, so it differs from both selects below
    pp_dir = 1'b1;
    dm(8'h00, 1'b1, 4'h1, 4'h1, 1'b1);
    dm(8'h80, 1'b1, 4'h4, 4'h4, 1'b0);
    $display("test drive map done");
    finish_test();
  end
endmodule
`default_nettype wire
